// >>> hw/aac_cfg.svh
// constants of the add arithmetic condition unit
// assumes inclusion by the unit; offsets are byte addresses on the bus
// Behaviour
// - positive flag bit 3 when result above zero
// - zero flag bit 2 when all bits zero
// - negative flag bit 1 when result below zero
// - overflow bit 0 on unbalanced sign carry
// - sum to second operand, first unchanged
// - opcode 30 increments memory word, sets flags
// - opcode 41 adds memory into index register
// - direct index ops unindexed, indirect may index
// - opcode 43 adds memory into accumulator
// - opcode 42 adds memory into extension
// - opcode 44 adds memory pair into double
// - low half bit 23 carries into high
// - double flags from whole double result
// - opcode 45 adds byte, bits 23-8 kept
// - opcode 46 adds index register into memory
// - opcode 50 adds accumulator into memory
// - opcode 47 adds extension into memory
// - opcode 0012 adds signed immediate byte
// - opcode 64 adds zero-extended immediate to register
// - double is extension high, accumulator low
`ifndef AAC_CFG_SVH
`define AAC_CFG_SVH

// register offsets
`define AAC_OFS_INSTR    8'h00
`define AAC_OFS_EA       8'h04
`define AAC_OFS_COND     8'h08
`define AAC_OFS_STAT     8'h0C
`define AAC_OFS_GPR      8'h10
`define AAC_OFS_LAST     8'h24

// reset values
`define AAC_RST_WORD     24'h000000
`define AAC_RST_COND     4'h0

// register file indices: code minus one
`define AAC_IDX_E        3'h3
`define AAC_IDX_A        3'h4

// opcodes, instruction bits 23-18
`define AAC_OP_INCR_MEM  6'h18
`define AAC_OP_MEM_IDX   6'h21
`define AAC_OP_MEM_EXT   6'h22
`define AAC_OP_MEM_ACC   6'h23
`define AAC_OP_MEM_DBL   6'h24
`define AAC_OP_MEM_BYTE  6'h25
`define AAC_OP_IDX_MEM   6'h26
`define AAC_OP_EXT_MEM   6'h27
`define AAC_OP_ACC_MEM   6'h28
`define AAC_OP_IMM_REG   6'h34
// twelve-bit opcode, instruction bits 23-12
`define AAC_OP_IMM_BYTE  12'h00A

// axi responses
`define AAC_RESP_OKAY    2'h0
`define AAC_RESP_SLVERR  2'h2

`endif

// >>> hw/aac_pkg.sv
// types of the add arithmetic condition unit
// assumes nothing beyond the unit that uses it
package aac_pkg;

    typedef enum logic [2:0] {
        AAC_IDLE = 3'h0,
        AAC_RD   = 3'h1,
        AAC_RD2  = 3'h5,
        AAC_EXEC = 3'h3,
        AAC_WR   = 3'h2
    } aac_state_e;

endpackage : aac_pkg

// >>> hw/aac_unit.sv
// add datapath with condition flags, axi4-lite register port
// assumes a memory on aclk that acks each request with one pulse
`timescale 1ns/1ns
`default_nettype none
`include "aac_cfg.svh"

module aac_unit (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // register bus, write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // register bus, read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // main memory
    output logic             mem_req,
    output logic             mem_we,
    output logic [14:0]      mem_addr,
    output logic [23:0]      mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [23:0] mem_rdata,
    // status
    output logic [3:0]       cond_flags,
    output logic             busy
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    aac_pkg::aac_state_e st_q;
    aac_pkg::aac_state_e st_d;
    logic [23:0]         gpr_q [6];
    logic [23:0]         instr_q;
    logic [14:0]         ea_q;
    logic [23:0]         md0_q;
    logic [23:0]         md1_q;
    logic [3:0]          cond_q;
    logic                bad_q;
    logic                aw_have_q;
    logic                w_have_q;
    logic [7:0]          awaddr_q;
    logic [31:0]         wdata_q;
    logic [3:0]          wstrb_q;
    logic                bvalid_q;
    logic [1:0]          bresp_q;
    logic                rvalid_q;
    logic [1:0]          rresp_q;
    logic [31:0]         rdata_q;
    logic                mem_req_q;
    logic                mem_we_q;
    logic [14:0]         mem_addr_q;
    logic [23:0]         mem_wdata_q;

    function automatic logic [23:0] merge(input logic [23:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        logic [23:0] r;
        r = o;
        for (int i = 0; i < 3; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------
    wire [5:0]  opc     = instr_q[23:18];
    wire        indir   = instr_q[17];
    wire [2:0]  rsel    = instr_q[17:15];
    wire [1:0]  xsel    = instr_q[16:15];
    wire [14:0] afield  = instr_q[14:0];
    wire        is_aob  = instr_q[23:12] == `AAC_OP_IMM_BYTE;
    wire        is_aor  = opc == `AAC_OP_IMM_REG;
    wire        is_dbl  = opc == `AAC_OP_MEM_DBL;
    wire        is_byte = is_aob | (opc == `AAC_OP_MEM_BYTE);
    wire        is_xop  = (opc == `AAC_OP_MEM_IDX) | (opc == `AAC_OP_IDX_MEM);
    wire        to_mem  = (opc == `AAC_OP_INCR_MEM) | (opc == `AAC_OP_IDX_MEM)
                        | (opc == `AAC_OP_EXT_MEM) | (opc == `AAC_OP_ACC_MEM);
    wire        to_reg  = (opc == `AAC_OP_MEM_IDX) | (opc == `AAC_OP_MEM_EXT)
                        | (opc == `AAC_OP_MEM_ACC) | is_dbl
                        | (opc == `AAC_OP_MEM_BYTE);
    wire        mem_op  = to_mem | to_reg;
    wire        op_ok   = (mem_op | is_aob | is_aor)
                        & (~is_xop | (xsel != 2'h0))
                        & (~is_aor | ((rsel != 3'h0) & (rsel != 3'h7)));
    wire [2:0]  ridx    = is_aor ? rsel - 3'h1 : {1'b0, xsel} - 3'h1;
    wire [2:0]  didx    = (is_aor | is_xop) ? ridx
                        : ((opc == `AAC_OP_MEM_EXT) | (opc == `AAC_OP_EXT_MEM))
                        ? `AAC_IDX_E : `AAC_IDX_A;
    // direct index references use the raw address field
    wire [14:0] effective_address     = (is_xop & ~indir) ? afield : ea_q;

    // ------------------------------------------------------------
    // adders and flags
    // ------------------------------------------------------------
    wire [23:0] opa  = (opc == `AAC_OP_INCR_MEM) ? 24'h000001
                     : gpr_q[didx];
    wire [23:0] opb  = is_aor ? {9'h000, afield} : md0_q;
    wire [23:0] ssum = opa + opb;
    wire        sovf = (opa[23] == opb[23]) & (ssum[23] != opa[23]);
    wire [7:0]  bb   = is_aob ? instr_q[7:0] : md0_q[7:0];
    wire [7:0]  bsum = opa[7:0] + bb;
    wire        bovf = (opa[7] == bb[7]) & (bsum[7] != opa[7]);
    // double: extension high word, accumulator low word
    wire [23:0] dlo  = gpr_q[`AAC_IDX_A] + md1_q;
    wire [23:0] dhi  = gpr_q[`AAC_IDX_E] + md0_q
                     + {23'h000000, dlo[23]};
    wire        dovf = (gpr_q[`AAC_IDX_E][23] == md0_q[23])
                     & (dhi[23] != gpr_q[`AAC_IDX_E][23]);
    wire [23:0] res  = is_byte ? {opa[23:8], bsum} : ssum;
    wire        f_z  = is_dbl ? ({dhi, dlo[22:0]} == 47'h0)
                     : is_byte ? (bsum == 8'h00)
                     : (ssum == 24'h000000);
    wire        f_n  = is_dbl ? dhi[23] : is_byte ? bsum[7]
                     : ssum[23];
    wire        f_v  = is_dbl ? dovf : is_byte ? bovf : sovf;
    wire [3:0]  flags = {~f_z & ~f_n, f_z, f_n, f_v};

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire        wr_fire = aw_have_q & w_have_q & ~bvalid_q;
    wire        wr_map  = (awaddr_q[1:0] == 2'h0)
                        & (awaddr_q <= `AAC_OFS_LAST);
    wire        wr_ok   = wr_fire & wr_map & (st_q == aac_pkg::AAC_IDLE);
    wire        start   = wr_ok & (awaddr_q == `AAC_OFS_INSTR);
    wire        exec    = st_q == aac_pkg::AAC_EXEC;
    wire        mem_done = mem_req_q & mem_ack;
    wire        issue   = ((st_q == aac_pkg::AAC_RD)
                        | (st_q == aac_pkg::AAC_RD2)
                        | (st_q == aac_pkg::AAC_WR)) & ~mem_req_q;
    wire [7:0]  ra      = s_axi_araddr;
    wire        rd_map  = (ra[1:0] == 2'h0) & (ra <= `AAC_OFS_LAST);
    wire [2:0]  rgi     = 3'(ra[7:2] - 6'h04);
    wire [23:0] rd_val  = (ra == `AAC_OFS_INSTR) ? instr_q
                        : (ra == `AAC_OFS_EA) ? {9'h000, ea_q}
                        : (ra == `AAC_OFS_COND) ? {20'h00000, cond_q}
                        : (ra == `AAC_OFS_STAT) ? {22'h000000, bad_q, busy}
                        : gpr_q[rgi];

    assign s_axi_awready = ~aw_have_q;
    assign s_axi_wready  = ~w_have_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign mem_req       = mem_req_q;
    assign mem_we        = mem_we_q;
    assign mem_addr      = mem_addr_q;
    assign mem_wdata     = mem_wdata_q;
    assign cond_flags    = cond_q;
    assign busy          = st_q != aac_pkg::AAC_IDLE;

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `AAC_RESP_OKAY;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
        end else begin
            if (s_axi_awvalid & ~aw_have_q) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid & ~w_have_q) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_map ? `AAC_RESP_OKAY : `AAC_RESP_SLVERR;
            end else if (bvalid_q & s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= `AAC_RESP_OKAY;
            rdata_q  <= 32'h00000000;
        end else if (s_axi_arvalid & ~rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_map ? `AAC_RESP_OKAY : `AAC_RESP_SLVERR;
            rdata_q  <= rd_map ? {8'h00, rd_val} : 32'h00000000;
        end else if (rvalid_q & s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        case (st_q)
            aac_pkg::AAC_IDLE: begin
                if (start) begin
                    st_d = aac_pkg::AAC_RD;
                end
            end
            aac_pkg::AAC_RD: begin
                if (!(mem_op & op_ok)) begin
                    st_d = aac_pkg::AAC_EXEC;
                end else if (mem_done) begin
                    st_d = is_dbl ? aac_pkg::AAC_RD2 : aac_pkg::AAC_EXEC;
                end
            end
            aac_pkg::AAC_RD2: begin
                if (mem_done) begin
                    st_d = aac_pkg::AAC_EXEC;
                end
            end
            aac_pkg::AAC_EXEC: begin
                st_d = (to_mem & op_ok) ? aac_pkg::AAC_WR
                                        : aac_pkg::AAC_IDLE;
            end
            aac_pkg::AAC_WR: begin
                if (mem_done) begin
                    st_d = aac_pkg::AAC_IDLE;
                end
            end
            default: st_d = aac_pkg::AAC_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= aac_pkg::AAC_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // memory port
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_req_q   <= 1'b0;
            mem_we_q    <= 1'b0;
            mem_addr_q  <= 15'h0000;
            mem_wdata_q <= `AAC_RST_WORD;
        end else if (mem_done) begin
            mem_req_q <= 1'b0;
        end else if (issue & (mem_op & op_ok)) begin
            mem_req_q  <= 1'b1;
            mem_we_q   <= st_q == aac_pkg::AAC_WR;
            mem_addr_q <= (st_q == aac_pkg::AAC_RD2) ? effective_address + 15'h0001
                                                     : effective_address;
        end else if (exec) begin
            mem_wdata_q <= res;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            md0_q <= `AAC_RST_WORD;
            md1_q <= `AAC_RST_WORD;
        end else if (mem_done & (st_q == aac_pkg::AAC_RD)) begin
            md0_q <= mem_rdata;
        end else if (mem_done & (st_q == aac_pkg::AAC_RD2)) begin
            md1_q <= mem_rdata;
        end
    end

    // ------------------------------------------------------------
    // control registers and flags
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_q <= `AAC_RST_WORD;
            ea_q    <= 15'h0000;
            cond_q  <= `AAC_RST_COND;
            bad_q   <= 1'b0;
        end else begin
            if (start) begin
                instr_q <= merge(instr_q, wdata_q, wstrb_q);
                bad_q   <= 1'b0;
            end
            if (wr_ok & (awaddr_q == `AAC_OFS_EA)) begin
                ea_q <= 15'(merge({9'h000, ea_q}, wdata_q, wstrb_q));
            end
            if (exec & op_ok) begin
                cond_q <= flags;
            end else if (wr_ok & (awaddr_q == `AAC_OFS_COND)) begin
                cond_q <= 4'(merge({20'h00000, cond_q}, wdata_q, wstrb_q));
            end
            if (exec & ~op_ok) begin
                bad_q <= 1'b1;
            end
        end
    end

    // one register per entry; only the named destination changes, or both E and A for a double add
    for (genvar g = 0; g < 6; g++) begin : g_gpr
        wire wr_g  = wr_ok & (awaddr_q == 8'(`AAC_OFS_GPR + 4 * g));
        wire ex_g  = exec & op_ok & ~to_mem;
        wire dst_g = didx == 3'(g);
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                gpr_q[g] <= `AAC_RST_WORD;
            end else if (ex_g & is_dbl & (3'(g) == `AAC_IDX_E)) begin
                gpr_q[g] <= dhi;
            end else if (ex_g & is_dbl & (3'(g) == `AAC_IDX_A)) begin
                gpr_q[g] <= {1'b0, dlo[22:0]};
            end else if (ex_g & ~is_dbl & dst_g) begin
                gpr_q[g] <= res;
            end else if (wr_g) begin
                gpr_q[g] <= merge(gpr_q[g], wdata_q, wstrb_q);
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wire [23:0] reg_a = gpr_q[`AAC_IDX_A];
    wire [23:0] reg_e = gpr_q[`AAC_IDX_E];
    wire ex_acc = exec & (opc == `AAC_OP_MEM_ACC);

    property p_acc_add;
        ex_acc |=> reg_a == $past(24'(reg_a + md0_q));
    endproperty
    a_acc_add: assert property (p_acc_add) else $error("acc add");
    property p_pos;
        ex_acc |=> cond_q[3] == (~reg_a[23] & (reg_a != 24'h000000));
    endproperty
    a_pos: assert property (p_pos) else $error("positive flag");
    property p_zero;
        ex_acc |=> cond_q[2] == (reg_a == 24'h000000);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    property p_neg;
        ex_acc |=> cond_q[1] == reg_a[23];
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag");
    property p_ovf;
        ex_acc |=> cond_q[0] == (($past(reg_a[23]) == $past(md0_q[23]))
                                 & (reg_a[23] != $past(reg_a[23])));
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag");
    property p_ext_add;
        exec & (opc == `AAC_OP_MEM_EXT)
            |=> reg_e == $past(24'(reg_e + md0_q)) && $stable(reg_a);
    endproperty
    a_ext_add: assert property (p_ext_add) else $error("ext add");
    property p_byte;
        exec & is_byte & op_ok |=> reg_a[23:8] == $past(reg_a[23:8])
            && reg_a[7:0] == $past(8'(reg_a[7:0] + bb));
    endproperty
    a_byte: assert property (p_byte) else $error("byte add");
    property p_dbl;
        exec & is_dbl & ~reg_a[23] & ~md1_q[23] |=> {reg_e, reg_a[22:0]}
            == $past(47'({reg_e, reg_a[22:0]} + {md0_q, md1_q[22:0]}));
    endproperty
    a_dbl: assert property (p_dbl) else $error("double add");
    property p_dbl_flags;
        exec & is_dbl |=> cond_q[1] == reg_e[23]
            && cond_q[2] == ({reg_e, reg_a[22:0]} == 47'h0);
    endproperty
    a_dbl_flags: assert property (p_dbl_flags)
        else $error("dbl flags");
    property p_store;
        exec & to_mem & op_ok |=> mem_wdata == $past(res)
            ##[1:1000] (mem_req & mem_we);
    endproperty
    a_store: assert property (p_store) else $error("store");
    property p_direct;
        mem_req & ~mem_we & (st_q == aac_pkg::AAC_RD) & is_xop & ~indir
            |-> mem_addr == afield;
    endproperty
    a_direct: assert property (p_direct) else $error("direct");
    property p_incr;
        exec & (opc == `AAC_OP_INCR_MEM) |=> mem_wdata == $past(md0_q + 24'h1);
    endproperty
    a_incr: assert property (p_incr) else $error("increment");

    c_dbl: cover property (exec & is_dbl ##1 cond_q[0]);
    c_store: cover property (mem_req & mem_we & mem_ack);
    c_imm: cover property (exec & is_aor & op_ok);
    c_bad: cover property (exec & ~op_ok);

endmodule : aac_unit

`default_nettype wire

// >>> verif/aac_mem_model.sv
// main memory model answering the unit with a random delay
// assumes one request at a time, held until the one-cycle ack
`timescale 1ns/1ns
`default_nettype none
module aac_mem_model (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // request side
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [14:0] mem_addr,
    input  wire logic [23:0] mem_wdata,
    output logic             mem_ack = 1'b0,
    output logic [23:0]      mem_rdata = 24'hA5A5A5
);
    logic [23:0] mem [0:32767];
    int          wait_q = 0;
    // rdata toggles whenever no request is answered
    always @(posedge aclk) begin
        if (!aresetn || mem_ack || !mem_req) begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_q    <= $urandom % 4;
        end else if (wait_q != 0) begin
            wait_q    <= wait_q - 1;
            mem_rdata <= ~mem_rdata;
        end else begin
            mem_ack   <= 1'b1;
            mem_rdata <= mem[mem_addr];
            if (mem_we)
                mem[mem_addr] <= mem_wdata;
        end
    end
endmodule : aac_mem_model
`default_nettype wire

// >>> verif/aac_unit_tb_top.sv
// bench comparing the unit with an integer model of the adds
// assumes the unit, its constants header and the memory model
`timescale 1ns/1ns
`default_nettype none
`include "aac_cfg.svh"
module aac_unit_tb_top;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got;
    logic [3:0]  s_axi_wstrb = 4'hF, cond_flags, c;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        mem_req, mem_we, mem_ack, busy;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [14:0] mem_addr;
    logic [23:0] mem_wdata, mem_rdata, ins;
    logic [23:0] r [6];
    logic [23:0] ev [4] = '{24'h7FFFFF, 24'h800000, 24'hFFFFFF, 24'h000001};
    logic [5:0]  ops [12] = '{`AAC_OP_INCR_MEM, `AAC_OP_MEM_IDX,
        `AAC_OP_MEM_EXT, `AAC_OP_MEM_ACC, `AAC_OP_MEM_DBL, `AAC_OP_MEM_BYTE,
        `AAC_OP_IDX_MEM, `AAC_OP_EXT_MEM, `AAC_OP_ACC_MEM, `AAC_OP_IMM_REG,
        6'h00, 6'h3F};
    logic [5:0]  op;
    logic [2:0]  x;
    int          err_total = 0;
    int          n_checks = 0;
    int          k;

    always #2 aclk = ~aclk;

    aac_unit dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_ack, .mem_rdata, .cond_flags, .busy
    );
    aac_mem_model mem_i (
        .aclk, .aresetn, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .mem_ack, .mem_rdata
    );

    // ----------------------------------------
    // reporting and bus tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    task automatic hang();
        err_total++;
        $display("unexpected handshake exp done got timeout");
        complete_run();
    endtask : hang

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic axi_wr(logic [7:0] a, logic [31:0] d, output logic [1:0] s);
        int i;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (i == 50) hang();
    endtask : axi_wr

    task automatic axi_rd(logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] s);
        int i;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        s = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (i == 50) hang();
    endtask : axi_rd

    // ----------------------------------------
    // integer model
    // ----------------------------------------
    function automatic logic [24:0] add(logic [23:0] a, logic [23:0] b,
                                        logic ci);
        logic [23:0] s;
        s = a + b + 24'(ci);
        return {a[23] == b[23] && s[23] != a[23], s};
    endfunction : add

    function automatic logic [3:0] fl(logic [23:0] v, logic o);
        return {!v[23] && v != 24'h0, v == 24'h0, v[23], o};
    endfunction : fl

    function automatic logic [23:0] rnd();
        return ($urandom % 2) ? 24'($urandom) : ev[$urandom % 4];
    endfunction : rnd

    task automatic run_op(logic [23:0] ins, logic [14:0] ea);
        logic [23:0] m, ml, p, q, s, l;
        logic [14:0] adr;
        logic [5:0]  op;
        logic [2:0]  x, d;
        logic [1:0]  j;
        logic        o, bt;
        int          i;
        op = ins[23:18];
        x = ins[17:15];
        j = x[1:0] - 2'h1;
        bt = op == `AAC_OP_MEM_BYTE || ins[23:12] == `AAC_OP_IMM_BYTE;
        adr = ea;
        if ((op == `AAC_OP_MEM_IDX || op == `AAC_OP_IDX_MEM) && !x[2])
            adr = ins[14:0];
        for (i = 0; i < 6; i++) begin
            r[i] = rnd();
            if (i == 4 && op == `AAC_OP_MEM_DBL) r[i][23] = 1'b0;
            axi_wr(8'(16 + 4 * i), {8'h00, r[i]}, rsp);
        end
        c = 4'($urandom);
        axi_wr(`AAC_OFS_COND, {28'h0, c}, rsp);
        m = rnd();
        ml = rnd() & 24'h7FFFFF;
        mem_i.mem[adr] = m;
        mem_i.mem[adr + 15'h1] = ml;
        axi_wr(`AAC_OFS_EA, {17'h0, ea}, rsp);
        axi_wr(`AAC_OFS_INSTR, {8'h00, ins}, rsp);
        for (i = 0; i < 200 && (i < 2 || busy); i++)
            @(posedge aclk);
        if (i == 200) hang();
        {d, p, q} = {3'h7, 48'h0};
        case (op)
            `AAC_OP_INCR_MEM: {d, p, q} = {3'h6, 24'h000001, m};
            `AAC_OP_MEM_IDX:  {d, p, q} = {1'b0, j, r[j], m};
            `AAC_OP_MEM_EXT:  {d, p, q} = {3'h3, r[3], m};
            `AAC_OP_MEM_ACC:  {d, p, q} = {3'h4, r[4], m};
            `AAC_OP_MEM_DBL:  {d, p, q} = {3'h7, r[4], ml};
            `AAC_OP_MEM_BYTE: {d, q} = {3'h4, m[7:0], 16'h0};
            `AAC_OP_IDX_MEM:  {d, p, q} = {3'h6, r[j], m};
            `AAC_OP_EXT_MEM:  {d, p, q} = {3'h6, r[3], m};
            `AAC_OP_ACC_MEM:  {d, p, q} = {3'h6, r[4], m};
            `AAC_OP_IMM_REG:
                {d, p, q} = {x - 3'h1, r[x - 3'h1], 9'h0, ins[14:0]};
            default:
                if (bt) {d, q} = {3'h4, ins[7:0], 16'h0};
        endcase
        if (bt) p = {r[4][7:0], 16'h0};
        {o, s} = add(p, q, 1'b0);
        if (d != 3'h7) c = fl(s, o);
        if (bt) s = {r[4][23:8], s[23:16]};
        if (d < 3'h6) r[d] = s;
        if (op == `AAC_OP_MEM_DBL) begin
            l = s;
            {o, s} = add(r[3], m, l[23]);
            r[3] = s;
            r[4] = {1'b0, l[22:0]};
            c = {!s[23] && {s, l[22:0]} != 0, {s, l[22:0]} == 0, s[23], o};
        end
        axi_rd(`AAC_OFS_COND, got, rsp);
        chk("cond reg", {28'h0, c}, got);
        chk("cond port", {28'h0, c}, 32'(cond_flags));
        for (i = 0; i < 6; i++) begin
            axi_rd(8'(16 + 4 * i), got, rsp);
            chk("register", {8'h00, r[i]}, got);
        end
        if (d == 3'h6) chk("memory", 32'(s), 32'(mem_i.mem[adr]));
        axi_rd(`AAC_OFS_STAT, got, rsp);
        chk("status", {30'h0, d == 3'h7 && op != `AAC_OP_MEM_DBL, 1'b0},
            got);
    endtask : run_op

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(29118));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (k = 4; k <= 36; k += 4) begin
            axi_rd(8'(k), got, rsp);
            chk("reset word", 32'h0, got);
        end
        axi_rd(8'h28, got, rsp);
        chk("unmapped read", {30'h0, `AAC_RESP_SLVERR}, {30'h0, rsp});
        axi_wr(8'h2C, 32'h0, rsp);
        chk("unmapped write", {30'h0, `AAC_RESP_SLVERR}, {30'h0, rsp});
        $display("test registers done");
        for (k = 0; k < 120; k++) begin
            op = ops[$urandom % 12];
            x = {1'($urandom), 2'($urandom % 3 + 1)};
            if (op == `AAC_OP_IMM_REG) x = 3'($urandom % 6 + 1);
            ins = {op, x, 15'($urandom)};
            if (op == 6'h00) ins = {`AAC_OP_IMM_BYTE, 4'h0, 8'($urandom)};
            run_op(ins, 15'($urandom % 32767));
        end
        $display("test instructions done");
        complete_run();
    end
endmodule : aac_unit_tb_top
`default_nettype wire
